// ### dv/pesm_err_sink.sv
/*
  Platform error handler model: counts request pulses arriving on the
  three error pins and on machine-check.
  Assumes registered one-cycle pulses from the port on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module pesm_err_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Requests from the port
  input  wire logic [2:0] err_pin_out,
  input  wire logic       machine_check_out,
  // Pulse counts: pins 0 to 2, then machine-check
  output var  int         hits [4]
);
  logic [3:0] req;

  // Every high cycle is one report, so back-to-back events count twice
  assign req = {machine_check_out, err_pin_out};
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      hits[i] <= rst ? 0 : hits[i] + int'(req[i]);
    end
  end
endmodule : pesm_err_sink

`default_nettype wire

// ### dv/pesm_port_test.sv
/*
  Testbench for the error steering port: both mask layouts side by side.
  Assumes registered answers one cycle after each strobe or event.
*/
`timescale 1ns/10ps
`default_nettype none

module pesm_port_test;
  logic        clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'hF;
  logic [31:0] cfg_wdata = 32'h0000_0000, rd_l, rd_r;
  logic [21:0] unc = 22'h00_0000, sev = 22'h00_0000, clr = 22'h00_0000;
  logic [21:0] fat_l, nf_l, fat_r, nf_r;
  logic        cor = 1'b0, ur = 1'b0, ur_en = 1'b1, mce_l, mce_r;
  logic [2:0]  pin_l, pin_r;
  int          hits [4];
  int          exp_hits [4] = '{0, 0, 0, 0};
  int          bad_count = 0, total_checks = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  pesm_port #(.LINK_PORT(1'b1)) dut_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rd_l), .unc_err_in(unc), .uncorrectable_severity_select(sev),
    .corr_err_in(cor), .ur_legacy_in(ur), .ur_report_en(ur_en), .err_pin_out(pin_l),
    .machine_check_out(mce_l), .fat_log_clr(clr), .nf_log_clr(clr), .fat_log(fat_l),
    .nf_log(nf_l));
  pesm_port #(.LINK_PORT(1'b0)) dut_root_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rd_r), .unc_err_in(unc), .uncorrectable_severity_select(sev),
    .corr_err_in(cor), .ur_legacy_in(ur), .ur_report_en(ur_en), .err_pin_out(pin_r),
    .machine_check_out(mce_r), .fat_log_clr(clr), .nf_log_clr(clr), .fat_log(fat_r),
    .nf_log(nf_r));
  pesm_err_sink sink_u (.clk(clk), .rst(rst), .err_pin_out(pin_l),
    .machine_check_out(mce_l), .hits(hits));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cfg_write(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask : cfg_write

  // Read data stands one cycle, sampled mid-cycle after the strobe, then drops to zero
  task automatic cfg_read(input logic [11:0] a, input logic [31:0] el, input logic [31:0] er);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    check("link rdata", el, rd_l);
    check("root rdata", er, rd_r);
    @(negedge clk);
    check("idle rdata", 32'h0000_0000, rd_l | rd_r);
  endtask : cfg_read

  // One event cycle; expected outputs are {machine-check, pins}
  task automatic fire(input logic [21:0] e, input logic [21:0] s, input logic c,
                      input logic u, input logic [3:0] xl, input logic [3:0] xr);
    @(negedge clk);
    unc = e;
    sev = s;
    cor = c;
    ur = u;
    @(negedge clk);
    unc = 22'h00_0000;
    cor = 1'b0;
    ur = 1'b0;
    check("link outputs", {28'h0000000, xl}, {28'h0000000, mce_l, pin_l});
    check("root outputs", {28'h0000000, xr}, {28'h0000000, mce_r, pin_r});
    for (int i = 0; i < 4; i++) exp_hits[i] += int'(xl[i]);
  endtask : fire

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    logic [1:0] code;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    cfg_read(12'h144, 32'h0000_0000, 32'h0000_0000);
    cfg_read(12'h148, 32'h0000_0000, 32'h0000_0000);
    cfg_write(12'h144, 32'hFFFF_FFFF);
    cfg_write(12'h148, 32'hFFFF_FFFE);
    cfg_write(12'h14C, 32'hFFFF_FFFF);
    cfg_read(12'h144, 32'h0000_00FF, 32'h0000_00FF);
    cfg_read(12'h14C, 32'h0000_0000, 32'h0000_0000);
    cfg_read(12'h148, 32'h0037_F010, 32'h0017_F030);
    // Lane 0 keeps its bits while its enable is low
    cfg_be = 4'hE;
    cfg_write(12'h148, 32'h0000_0000);
    cfg_be = 4'hF;
    cfg_read(12'h148, 32'h0000_0010, 32'h0000_0030);
    cfg_write(12'h148, 32'h0000_0000);
    // Each class on its own field; fields rotate so every code meets every class
    for (int f = 0; f < 4; f++) begin
      code = 2'(f);
      cfg_write(12'h144, {24'h000000, code, code + 2'h1, code + 2'h2, code + 2'h3});
      fire(22'h00_1000, 22'h00_1000, 1'b0, 1'b0, 4'h1 << code, 4'h1 << code);
      fire(22'h00_1000, 22'h00_0000, 1'b0, 1'b0, 4'h1 << 2'(code + 2'h1),
           4'h1 << 2'(code + 2'h1));
      fire(22'h00_0000, 22'h00_0000, 1'b1, 1'b0, 4'h1 << 2'(code + 2'h2),
           4'h1 << 2'(code + 2'h2));
      fire(22'h00_0000, 22'h00_0000, 1'b0, 1'b1, 4'h1 << 2'(code + 2'h3),
           4'h1 << 2'(code + 2'h3));
    end
    ur_en = 1'b0;
    fire(22'h00_0000, 22'h00_0000, 1'b0, 1'b1, 4'h0, 4'h0);
    ur_en = 1'b1;
    // one fatal and one non-fatal source logged so far
    check("fatal log early", 32'h0000_1000, {10'h000, fat_l});
    check("nonfatal log early", 32'h0000_1000, {10'h000, nf_l});
    check("root fatal log early", 32'h0000_1000, {10'h000, fat_r});
    // Reset in mid-run drops steering to pin 0; the sink restarts its counts
    @(negedge clk);
    rst = 1'b1;
    exp_hits = '{0, 0, 0, 0};
    @(negedge clk);
    rst = 1'b0;
    cfg_read(12'h144, 32'h0000_0000, 32'h0000_0000);
    check("reset log", 32'h0000_0000, {10'h000, fat_l | nf_l | fat_r});
    // Mask bits 1 to 21 alone: masked gives silence, unmasked writable bits reach pin 0
    for (int b = 1; b < 22; b++) begin
      cfg_write(12'h148, 32'h1 << b);
      fire(22'h1 << b, 22'h1 << b, 1'b0, 1'b0, 4'h0, 4'h0);
      cfg_write(12'h148, 32'h0000_0000);
      fire(22'h1 << b, 22'h1 << b, 1'b0, 1'b0, {3'h0, pesm_pkg::PESM_LINK_WMASK[b]},
           {3'h0, pesm_pkg::PESM_ROOT_WMASK[b]});
    end
    check("fatal log", 32'h0037_F010, {10'h000, fat_l});
    check("nonfatal log", 32'h0000_0000, {10'h000, nf_l});
    check("root fatal log", 32'h0017_F030, {10'h000, fat_r});
    check("root nonfatal log", 32'h0000_0000, {10'h000, nf_r});
    @(negedge clk);
    clr = 22'h3F_FFFF;
    @(negedge clk);
    clr = 22'h00_0000;
    check("cleared log", 32'h0000_0000, {10'h000, fat_l | fat_r});
    // A new error in the clearing cycle must survive the clear
    @(negedge clk);
    unc = 22'h00_1000;
    sev = 22'h00_1000;
    clr = 22'h3F_FFFF;
    @(negedge clk);
    unc = 22'h00_0000;
    clr = 22'h00_0000;
    exp_hits[0]++;
    check("set over clear", 32'h0000_1000, {10'h000, fat_l});
    // Let the sink count the last pulse before comparing
    @(negedge clk);
    for (int i = 0; i < 4; i++) check("handler count", 32'(exp_hits[i]), 32'(hits[i]));
    give_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #2_000_000;
    bad_count++;
    give_verdict();
  end
endmodule : pesm_port_test

`default_nettype wire

// ### hdl/pesm_port.sv
/*
  Per-port error steering and uncorrectable detection mask, with sticky
  logs that gather every unmasked fatal and non-fatal error.
  Assumes error events and their severity arrive as one-cycle pulses from
  logic on the same clock, and configuration accesses as single-cycle
  strobes. LINK_PORT selects the south-bridge link mask layout.
*/
`timescale 1ns/10ps
`default_nettype none

module pesm_port #(
  parameter bit LINK_PORT = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  // Error events
  input  wire logic [21:0] unc_err_in,
  input  wire logic [21:0] uncorrectable_severity_select,
  input  wire logic        corr_err_in,
  input  wire logic        ur_legacy_in,
  input  wire logic        ur_report_en,
  // Error signalling
  output logic      [2:0]  err_pin_out,
  output logic             machine_check_out,
  // Sticky error logs and their write-one clears
  input  wire logic [21:0] fat_log_clr,
  input  wire logic [21:0] nf_log_clr,
  output logic      [21:0] fat_log,
  output logic      [21:0] nf_log
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [31:0] WMASK = LINK_PORT ? pesm_pkg::PESM_LINK_WMASK
                                            : pesm_pkg::PESM_ROOT_WMASK;
  logic [31:0] steer_reg;
  logic [31:0] mask_reg;
  logic [31:0] next_steer_reg;
  logic [31:0] next_mask_reg;
  logic [31:0] next_cfg_rdata;
  logic [21:0] unc_live;
  logic [21:0] fat_hit;
  logic [21:0] nf_hit;
  logic        ur_live;
  logic [3:0]  route;
  logic [2:0]  next_err_pin_out;
  logic        next_machine_check_out;
  logic [21:0] next_fat_log;
  logic [21:0] next_nf_log;

  // Byte-enable merge of a write into the writable bits only
  function automatic logic [31:0] pesm_merge(input logic [31:0] cur, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    pesm_merge = (cur & ~bm) | (wd & bm);
  endfunction : pesm_merge

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Reads answer one cycle after the strobe; unmapped offsets read zero
  always_comb begin
    next_steer_reg = steer_reg;
    next_mask_reg  = mask_reg;
    next_cfg_rdata = pesm_pkg::PESM_ZERO32;
    if (cfg_wr && cfg_addr == pesm_pkg::PESM_OFS_STEER) begin
      next_steer_reg = pesm_merge(steer_reg, cfg_wdata, cfg_be, pesm_pkg::PESM_STEER_WMASK);
    end else if (cfg_wr && cfg_addr == pesm_pkg::PESM_OFS_MASK) begin
      next_mask_reg = pesm_merge(mask_reg, cfg_wdata, cfg_be, WMASK);
    end
    if (cfg_rd && cfg_addr == pesm_pkg::PESM_OFS_STEER) begin
      next_cfg_rdata = steer_reg;
    end else if (cfg_rd && cfg_addr == pesm_pkg::PESM_OFS_MASK) begin
      next_cfg_rdata = mask_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      steer_reg <= pesm_pkg::PESM_RST_STEER;
      mask_reg  <= pesm_pkg::PESM_RST_MASK;
      cfg_rdata <= pesm_pkg::PESM_ZERO32;
    end else begin
      steer_reg <= next_steer_reg;
      mask_reg  <= next_mask_reg;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Detection and classification
  // ----------------------------------------------------------------------
  // masked errors dropped here
  // Reserved positions never raise an event, so a stray input is inert.
  // Bit 0 (training) is stored but its effect is unspecified for software.
  // per-bit blocking
  assign unc_live = unc_err_in & ~mask_reg[21:0] & WMASK[21:0];
  assign fat_hit  = unc_live & uncorrectable_severity_select;
  assign nf_hit   = unc_live & ~uncorrectable_severity_select;
  assign ur_live  = ur_legacy_in & ur_report_en & ~mask_reg[pesm_pkg::PESM_MSK_UR];

  pesm_route u_route (
    .fat_ev (|fat_hit),
    .nf_ev  (|nf_hit),
    .cor_ev (corr_err_in),
    .ur_ev  (ur_live),
    .steer  (steer_reg[7:0]),
    .route  (route)
  );

  // ----------------------------------------------------------------------
  // Signalling and logs
  // ----------------------------------------------------------------------
  // Pins pulse one cycle after the event; a log set beats a same-cycle clear
  always_comb begin
    next_err_pin_out       = route[2:0];
    next_machine_check_out = route[3];
    next_fat_log = (fat_log & ~fat_log_clr) | fat_hit;
    next_nf_log  = (nf_log & ~nf_log_clr) | nf_hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      err_pin_out       <= 3'h0;
      machine_check_out <= 1'h0;
      fat_log           <= 22'h0;
      nf_log            <= 22'h0;
    end else begin
      err_pin_out       <= next_err_pin_out;
      machine_check_out <= next_machine_check_out;
      fat_log           <= next_fat_log;
      nf_log            <= next_nf_log;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fat_to_mce_a: assert property (
    (|fat_hit && steer_reg[pesm_pkg::PESM_FAT_LSB +: 2] == pesm_pkg::PESM_ROUTE_MCE)
      |=> machine_check_out)
    else $error("fatal error not on machine-check");
  nf_to_pin1_a: assert property (
    (|nf_hit && steer_reg[pesm_pkg::PESM_NF_LSB +: 2] == pesm_pkg::PESM_ROUTE_PIN1)
      |=> err_pin_out[1])
    else $error("non-fatal error not on pin 1");
  cor_to_pin2_a: assert property (
    (corr_err_in && steer_reg[pesm_pkg::PESM_COR_LSB +: 2] == pesm_pkg::PESM_ROUTE_PIN2)
      |=> err_pin_out[2])
    else $error("correctable error not on pin 2");
  ur_gate_a: assert property (
    (ur_legacy_in && !ur_report_en && unc_err_in == 22'h0 && !corr_err_in)
      |=> (err_pin_out == 3'h0 && !machine_check_out))
    else $error("disabled unsupported request signalled");
  ur_route_a: assert property (
    (ur_live && steer_reg[pesm_pkg::PESM_UR_LSB +: 2] == pesm_pkg::PESM_ROUTE_PIN0)
      |=> err_pin_out[0])
    else $error("unsupported request not on pin 0");
  masked_silent_a: assert property (
    (unc_err_in != 22'h0 && (unc_err_in & ~mask_reg[21:0]) == 22'h0
      && !corr_err_in && !ur_legacy_in && fat_log_clr == 22'h0 && nf_log_clr == 22'h0)
      |=> (err_pin_out == 3'h0 && !machine_check_out && $stable(fat_log) && $stable(nf_log)))
    else $error("masked error leaked");
  mask_layout_a: assert property (
    (mask_reg & ~WMASK) == pesm_pkg::PESM_ZERO32 && steer_reg[31:8] == 24'h0)
    else $error("reserved bit held a one");
  steer_read_a: assert property (
    (cfg_rd && !cfg_wr && cfg_addr == pesm_pkg::PESM_OFS_STEER)
      |=> cfg_rdata == $past(steer_reg))
    else $error("steering read mismatch");
  sev_split_a: assert property (
    (fat_hit != 22'h0 && fat_log_clr == 22'h0) |=> (fat_log & $past(fat_hit)) == $past(fat_hit))
    else $error("fatal log bit not set");
  reset_zero_a: assert property (
    $past(rst) |-> (steer_reg == pesm_pkg::PESM_RST_STEER && mask_reg == pesm_pkg::PESM_RST_MASK))
    else $error("registers not cleared by reset");

  fat_mce_c: cover property (|fat_hit ##1 machine_check_out);
  masked_c:  cover property (unc_err_in != 22'h0 && unc_live == 22'h0);
  set_clr_c: cover property ((fat_hit & fat_log_clr) != 22'h0);
  ur_rep_c:  cover property (ur_live);

endmodule : pesm_port

`default_nettype wire

// ### hdl/pesm_route.sv
/*
  Steering decoder: turns four class events and the steering register
  into requests on three error pins and machine-check, one-hot per class.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
`default_nettype none

module pesm_route (
  // Class events
  input  wire logic       fat_ev,
  input  wire logic       nf_ev,
  input  wire logic       cor_ev,
  input  wire logic       ur_ev,
  // Steering register contents
  input  wire logic [7:0] steer,
  // Requests: bits 2:0 error pins, bit 3 machine-check
  output logic      [3:0] route
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic logic [3:0] pesm_onehot(input logic ev, input logic [1:0] sel);
    pesm_onehot = ev ? (4'h1 << sel) : 4'h0;
  endfunction : pesm_onehot

  // Classes may fire together; the pins simply merge
  always_comb begin
    route = pesm_onehot(fat_ev, steer[pesm_pkg::PESM_FAT_LSB +: 2]);
    route = route | pesm_onehot(nf_ev, steer[pesm_pkg::PESM_NF_LSB +: 2]);
    route = route | pesm_onehot(cor_ev, steer[pesm_pkg::PESM_COR_LSB +: 2]);
    route = route | pesm_onehot(ur_ev, steer[pesm_pkg::PESM_UR_LSB +: 2]);
  end

endmodule : pesm_route

`default_nettype wire

// ### inc/pesm_pkg.sv
/*
  Constants for the error steering and detection mask block: register
  offsets, writable-bit layouts, field positions and reset values.
  Assumes a configuration access path that presents 12-bit byte offsets.
*/
package pesm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets in configuration space
  // ----------------------------------------------------------------------
  localparam logic [11:0] PESM_OFS_STEER = 12'h144;
  localparam logic [11:0] PESM_OFS_MASK  = 12'h148;

  // ----------------------------------------------------------------------
  // Steering register fields
  // ----------------------------------------------------------------------
  localparam int PESM_FAT_LSB = 6;
  localparam int PESM_NF_LSB  = 4;
  localparam int PESM_COR_LSB = 2;
  localparam int PESM_UR_LSB  = 0;
  localparam logic [31:0] PESM_STEER_WMASK = 32'h0000_00FF;

  // Route codes: three error pins, then the machine-check signal
  localparam logic [1:0] PESM_ROUTE_PIN0 = 2'h0;
  localparam logic [1:0] PESM_ROUTE_PIN1 = 2'h1;
  localparam logic [1:0] PESM_ROUTE_PIN2 = 2'h2;
  localparam logic [1:0] PESM_ROUTE_MCE  = 2'h3;

  // ----------------------------------------------------------------------
  // Uncorrectable mask bit positions
  // ----------------------------------------------------------------------
  localparam int PESM_MSK_LINK_RST  = 21;
  localparam int PESM_MSK_UR        = 20;
  localparam int PESM_MSK_MALFORMED = 18;
  localparam int PESM_MSK_RX_OVF    = 17;
  localparam int PESM_MSK_UNEXP_CPL = 16;
  localparam int PESM_MSK_CPL_ABORT = 15;
  localparam int PESM_MSK_CPL_TMO   = 14;
  localparam int PESM_MSK_FC_PROT   = 13;
  localparam int PESM_MSK_POISONED  = 12;
  localparam int PESM_MSK_SURPRISE  = 5;
  localparam int PESM_MSK_DL_PROT   = 4;
  localparam int PESM_MSK_TRAINING  = 0;

  // Writable bits of each mask layout; all others are reserved
  localparam logic [31:0] PESM_LINK_WMASK = 32'h0037_F011;
  localparam logic [31:0] PESM_ROOT_WMASK = 32'h0017_F031;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int          PESM_UNC_W     = 22;
  localparam logic [31:0] PESM_RST_STEER = 32'h0000_0000;
  localparam logic [31:0] PESM_RST_MASK  = 32'h0000_0000;
  localparam logic [31:0] PESM_ZERO32    = 32'h0000_0000;

endpackage : pesm_pkg
